// >>> design/rfcm_clash_tracker.sv
// Purpose: counts data bits of a frame and finds its first bit collision
// Assumes: event pulses come from receiver logic on the same clock
// Notes:   live result; the register bank commits it at frame end
`timescale 1ns/1ps
`include "rfcm_consts.svh"

module rfcm_clash_tracker
  import rfcm_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire rfcm_rx_event_type     rx_event,
  output rfcm_clash_report_type      report,
  output logic                       clash_seen
);

  logic [6:0] bit_count;
  logic [6:0] next_position;

  // One-based position of the bit now arriving
  assign next_position = bit_count + 7'h01;

  // Only data bits advance the count; saturates past the field range
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_count <= 7'h00;
    end else if (rx_event.frame_start) begin
      bit_count <= 7'h00;
    end else if (rx_event.data_bit && bit_count != 7'h7f) begin
      bit_count <= next_position; // RULE5
    end
  end

  // First collision only; later ones leave the capture alone
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clash_seen <= 1'b0;
      report     <= '{invalid: 1'b1, position: 5'h00};
    end else if (rx_event.frame_start) begin
      clash_seen <= 1'b0;
      report     <= '{invalid: 1'b1, position: 5'h00};
    end else if (rx_event.data_bit && rx_event.bit_collision
                 && !clash_seen) begin
      clash_seen <= 1'b1;
      // Bit 32 and bit 128 onward read as zero; bits 33 to 127 are out of range
      report.invalid  <= (next_position > `RFCM_POS_LIMIT); // RULE3
      report.position <= next_position[4:0]; // RULE4 RULE6 RULE7
    end
  end

  first_bit_one_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
    rx_event.data_bit && rx_event.bit_collision && !clash_seen
    && !rx_event.frame_start && bit_count == 7'h00
    |=> report.position == 5'h01 && !report.invalid)
    else $error("first data bit collision not reported as one");

  bit_wrap_zero_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
    rx_event.data_bit && rx_event.bit_collision && !clash_seen
    && !rx_event.frame_start && bit_count == 7'h1f
    |=> report.position == 5'h00 && !report.invalid)
    else $error("collision in bit 32 not reported as zero");

  count_data_only_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
    !rx_event.data_bit && !rx_event.frame_start |=> $stable(bit_count))
    else $error("bit count moved without a data bit");

endmodule

// >>> design/rfcm_mode_regs.sv
// Purpose: collision capture and RF mode registers with frame control
// Assumes: register strobes and receiver events share clk; nrst is a pin
// Notes:   read data is registered, one cycle after the read strobe
//
// Behaviour
// RULE1 - With keep bit clear, bits after a collision are dropped.
// RULE2 - Host clears keep bit only for 106 kBd bitwise anticollision.
// RULE3 - Invalid flag set when no collision or position out of range; a collision at bit 128 or later reads as valid position zero.
// RULE4 - Bits 4 to 0 hold the first collision position of a frame.
// RULE5 - Only data bits are counted toward the position.
// RULE6 - Position is one-based: 01h first bit, 08h eighth bit.
// RULE7 - Collision in bit 32 reads as position zero.
// RULE8 - Host reads the position only while the invalid flag is 0.
// RULE9 - Collision register content after reset is not to be relied on.
// RULE10 - Addresses 0Fh and 10h do nothing and read 00h.
// RULE11 - General mode register resets to 3Fh with bits 7,5,3,1:0 writable.
// RULE12 - Transmit checksum enable makes the sender append a CRC.
// RULE13 - Host clears transmit checksum enable only at 106 kBd.
// RULE14 - Send rate codes 000 to 011 are 106 to 848 kBd, rest reserved.
// RULE15 - Invert modulation bit inverts modulation of sent data.
// RULE16 - Receive mode register resets to 00h, bits 1:0 reserved.
// RULE17 - Receive checksum enable makes the receiver check the CRC.
// RULE18 - Receive rate field decodes like the send rate field.
// RULE19 - Single frame mode stops receiver; multi mode appends error copy.
// RULE20 - With ignore bit set, streams under four bits are ignored.
// RULE21 - Collision result updates per frame and holds until the next.
`timescale 1ns/1ps
`include "rfcm_consts.svh"

module rfcm_mode_regs
  import rfcm_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire logic [5:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic [7:0]                 reg_rdata,
  input  wire rfcm_rx_event_type     rx_event,
  input  wire logic                  rx_start_cmd,
  input  wire logic                  rx_stop_cmd,
  output logic                       bit_keep,
  output logic                       rx_active,
  output logic                       rx_done,
  output logic                       append_error_copy,
  output rfcm_mode_cfg_type          mode_cfg
);

  logic                  rst_meta;
  logic                  rst_n;
  logic [7:0]            collision_capture;
  logic [7:0]            general_link_mode;
  logic [7:0]            transmit_mode;
  logic [7:0]            receive_mode;
  rfcm_clash_report_type live_report;
  logic                  clash_seen;
  logic                  short_ignored;
  logic                  frame_close;
  logic                  commit;
  rfcm_rcv_state_type    rcv_state;
  rfcm_rcv_state_type    next_rcv_state;
  logic                  wr_collision;
  logic                  wr_general;
  logic                  wr_transmit;
  logic                  wr_receive;

  // Reset release passes two flops so every flop leaves reset together
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Collision search for the frame in flight
  rfcm_clash_tracker u_tracker (
    .clk        (clk),
    .rst_n      (rst_n),
    .rx_event   (rx_event),
    .report     (live_report),
    .clash_seen (clash_seen)
  );

  // Short stream counts as no frame when ignoring is enabled
  assign short_ignored = rx_event.frame_end && rx_event.short_stream
                         && receive_mode[`RFCM_BIT_IGNORE_SHORT]; // RULE20
  assign frame_close   = rx_event.frame_end && !short_ignored;
  assign commit        = frame_close && rcv_state == RCV_ACTIVE;

  // Write decode
  assign wr_collision = reg_wr && reg_addr == `RFCM_ADDR_COLLISION;
  assign wr_general   = reg_wr && reg_addr == `RFCM_ADDR_GENERAL;
  assign wr_transmit  = reg_wr && reg_addr == `RFCM_ADDR_TRANSMIT;
  assign wr_receive   = reg_wr && reg_addr == `RFCM_ADDR_RECEIVE;

  // Bits after the first collision pass only when the keep bit is set
  assign bit_keep = rx_event.data_bit && rcv_state == RCV_ACTIVE
                    && (!clash_seen
                        || collision_capture[`RFCM_BIT_KEEP_AFTER]); // RULE1

  // Collision register: host owns the keep bit, hardware owns the rest.
  // Reset value is defined only to keep simulation clean.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      collision_capture <= `RFCM_RST_COLLISION; // RULE9
    end else begin
      if (wr_collision) begin
        collision_capture[`RFCM_BIT_KEEP_AFTER] <=
          reg_wdata[`RFCM_BIT_KEEP_AFTER];
      end
      // Result replaced only when a frame closes, held otherwise
      if (commit) begin
        collision_capture[`RFCM_BIT_POS_INVALID] <=
          live_report.invalid; // RULE3 RULE21
        collision_capture[4:0] <= live_report.position; // RULE4 RULE21
      end
    end
  end

  // General mode: reserved bits keep their reset value
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      general_link_mode <= `RFCM_RST_GENERAL; // RULE11
    end else if (wr_general) begin
      general_link_mode <= (general_link_mode & ~`RFCM_WMASK_GENERAL)
                           | (reg_wdata & `RFCM_WMASK_GENERAL); // RULE11
    end
  end

  // Transmit mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      transmit_mode <= `RFCM_RST_TRANSMIT;
    end else if (wr_transmit) begin
      transmit_mode <= reg_wdata & `RFCM_WMASK_TRANSMIT;
    end
  end

  // Receive mode: bits 1:0 stay zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      receive_mode <= `RFCM_RST_RECEIVE; // RULE16
    end else if (wr_receive) begin
      receive_mode <= reg_wdata & `RFCM_WMASK_RECEIVE; // RULE16
    end
  end

  // Registered read port; holes and reserved slots read zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `RFCM_ADDR_COLLISION: reg_rdata <= collision_capture;
        `RFCM_ADDR_RSVD_A:    reg_rdata <= `RFCM_RST_RSVD; // RULE10
        `RFCM_ADDR_RSVD_B:    reg_rdata <= `RFCM_RST_RSVD; // RULE10
        `RFCM_ADDR_GENERAL:   reg_rdata <= general_link_mode;
        `RFCM_ADDR_TRANSMIT:  reg_rdata <= transmit_mode;
        `RFCM_ADDR_RECEIVE:   reg_rdata <= receive_mode;
        default:              reg_rdata <= 8'h00;
      endcase
    end
  end

  // Receiver activity; a stop command wins over a frame close
  always_comb begin
    next_rcv_state = rcv_state;
    case (rcv_state)
      RCV_IDLE: begin
        if (rx_start_cmd) begin
          next_rcv_state = RCV_ACTIVE;
        end
      end
      RCV_ACTIVE: begin
        if (rx_stop_cmd) begin
          next_rcv_state = RCV_IDLE;
        end else if (frame_close
                     && !receive_mode[`RFCM_BIT_MULTI_FRAME]) begin
          next_rcv_state = RCV_IDLE; // RULE19
        end
      end
      default: next_rcv_state = RCV_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rcv_state <= RCV_IDLE;
    end else begin
      rcv_state <= next_rcv_state;
    end
  end

  assign rx_active = rcv_state == RCV_ACTIVE;

  // Frame-end pulses for the buffer and command logic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_done           <= 1'b0;
      append_error_copy <= 1'b0;
    end else begin
      rx_done           <= commit
                           && !receive_mode[`RFCM_BIT_MULTI_FRAME]; // RULE19
      append_error_copy <= commit
                           && receive_mode[`RFCM_BIT_MULTI_FRAME]; // RULE19
    end
  end

  // Settings out of flops so the datapaths see no decode glitches
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_cfg <= '0;
    end else begin
      mode_cfg.high_bit_first <=
        general_link_mode[`RFCM_BIT_HIGH_FIRST];
      mode_cfg.send_wait_for_field <=
        general_link_mode[`RFCM_BIT_WAIT_FIELD];
      mode_cfg.card_input_polarity <=
        general_link_mode[`RFCM_BIT_CARD_POL];
      mode_cfg.checksum_preset_select <= general_link_mode[1:0];
      mode_cfg.send_checksum_enable <=
        transmit_mode[`RFCM_BIT_CRC_EN]; // RULE12
      mode_cfg.send_bit_rate <= transmit_mode[6:4]; // RULE14
      mode_cfg.send_rate_legal <=
        transmit_mode[6:4] <= `RFCM_RATE_MAX; // RULE14
      mode_cfg.invert_modulation <=
        transmit_mode[`RFCM_BIT_INV_MOD]; // RULE15
      mode_cfg.receive_checksum_enable <=
        receive_mode[`RFCM_BIT_CRC_EN]; // RULE17
      mode_cfg.receive_bit_rate <= receive_mode[6:4]; // RULE18
      mode_cfg.receive_rate_legal <=
        receive_mode[6:4] <= `RFCM_RATE_MAX; // RULE18
      mode_cfg.ignore_short_stream <=
        receive_mode[`RFCM_BIT_IGNORE_SHORT]; // RULE20
      mode_cfg.multi_frame_receive <=
        receive_mode[`RFCM_BIT_MULTI_FRAME]; // RULE19
      mode_cfg.keep_bits_after_clash <=
        collision_capture[`RFCM_BIT_KEEP_AFTER]; // RULE1
    end
  end

  // Checks

  drop_after_clash_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
    rx_event.data_bit && clash_seen
    && !collision_capture[`RFCM_BIT_KEEP_AFTER] |-> !bit_keep)
    else $error("bit after collision was kept");

  no_clash_invalid_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
    commit && !clash_seen |=> collision_capture[`RFCM_BIT_POS_INVALID])
    else $error("invalid flag clear with no collision");

  position_commit_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
    commit |=> collision_capture[4:0] == $past(live_report.position))
    else $error("collision position not taken at frame end");

  reserved_reads_zero_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE10
    reg_rd && (reg_addr == `RFCM_ADDR_RSVD_A
               || reg_addr == `RFCM_ADDR_RSVD_B) |=> reg_rdata == 8'h00)
    else $error("reserved address read nonzero");

  general_reserved_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE11
    wr_general && reg_wdata == 8'h00 ##1 reg_rd
    && reg_addr == `RFCM_ADDR_GENERAL && !wr_general
    |=> reg_rdata == 8'h14)
    else $error("general mode reserved bits changed by write");

  single_frame_stop_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE19
    commit && !receive_mode[`RFCM_BIT_MULTI_FRAME]
    |=> rx_done && !append_error_copy ##1 !rx_done)
    else $error("single frame did not stop receiver");

  short_ignored_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE20
    short_ignored && rx_active && !rx_stop_cmd
    |=> rx_active && !rx_done && $stable(collision_capture[5:0]))
    else $error("ignored short stream ended reception");

  result_holds_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE21
    !commit |=> $stable(collision_capture[5:0]))
    else $error("collision result changed between frames");

  send_rate_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE14
    wr_transmit ##2 !$past(wr_transmit)
    |-> mode_cfg.send_rate_legal == (transmit_mode[6:4] <= 3'h3))
    else $error("send rate legality wrong");

endmodule

// >>> dv/rf_collision_and_mode_regs_tb_top.sv
// Purpose: self-checking bench of the collision and mode registers
// Assumes: strobe register port, card model on the receiver events
// Notes:   random register data from a fixed seed, corner positions
`timescale 1ns/1ps
`include "rfcm_consts.svh"
module rf_collision_and_mode_regs_tb_top;
  import rfcm_pkg::*;
  logic              clk, nrst, reg_wr, reg_rd, bit_keep, rx_active;
  logic              rx_start_cmd, rx_stop_cmd, rx_done, append_error_copy;
  logic              go, short_f, busy, keep_bit, after_clash;
  logic [5:0]        reg_addr;
  logic [6:0]        nbits, coll_at;
  logic [7:0]        reg_wdata, reg_rdata, d, v, last;
  rfcm_rx_event_type rx_event;
  rfcm_mode_cfg_type mode_cfg;
  int                miscompares, comparisons, cyc, k, c, done_cnt, app_cnt;
  int                pos_tab[6] = '{1, 8, 32, 33, 0, 0};

  rfcm_mode_regs uut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_event(rx_event),
    .rx_start_cmd(rx_start_cmd), .rx_stop_cmd(rx_stop_cmd),
    .bit_keep(bit_keep), .rx_active(rx_active), .rx_done(rx_done),
    .append_error_copy(append_error_copy), .mode_cfg(mode_cfg));
  rfcm_card_model card (.clk(clk), .go(go), .nbits(nbits),
    .coll_at(coll_at), .short_f(short_f), .rx_event(rx_event), .busy(busy));

  task automatic report_and_stop();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] val);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= val;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] q);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask
  task automatic pulse_stop();
    @(posedge clk);
    rx_stop_cmd <= 1'b1;
    @(posedge clk);
    rx_stop_cmd <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // One card frame, optionally preceded by a receive command
  task automatic frame(input int n, input int cp, input logic s,
                       input logic start);
    int w;
    @(posedge clk);
    rx_start_cmd <= start;
    @(posedge clk);
    rx_start_cmd <= 1'b0;
    nbits <= 7'(n);
    coll_at <= 7'(cp);
    short_f <= s;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    for (w = 0; w < 200 && busy === 1'b1; w++) @(posedge clk);
    repeat (3) @(posedge clk);
  endtask
  function automatic logic [7:0] exp_general(input logic [7:0] val);
    return (val & `RFCM_WMASK_GENERAL) | (8'h3f & ~`RFCM_WMASK_GENERAL);
  endfunction

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Hang guard, far above the length of all tests
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  always @(posedge clk) begin
    if (rx_done === 1'b1) done_cnt++;
    if (append_error_copy === 1'b1) app_cnt++;
  end
  // Bits after a clash must be dropped while the keep bit is clear
  always @(negedge clk) begin
    if (rx_event.frame_start === 1'b1) after_clash = 1'b0;
    if (rx_event.data_bit === 1'b1) begin
      if (after_clash) check(8'(bit_keep), 8'(keep_bit));
      if (rx_event.bit_collision === 1'b1) after_clash = 1'b1;
    end
  end

  initial begin
    {nrst, reg_wr, reg_rd, rx_start_cmd, rx_stop_cmd, go, short_f} = '0;
    {reg_addr, reg_wdata, nbits, coll_at} = '0;
    after_clash = 1'b0;
    void'($urandom(97));
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    // Reset values, unmapped read returns zero
    rd(6'h0f, d); check(d, 8'h00);
    rd(6'h10, d); check(d, 8'h00);
    rd(6'h11, d); check(d, 8'h3f);
    rd(6'h12, d); check(d, 8'h00);
    rd(6'h13, d); check(d, 8'h00);
    rd(6'h3f, d); check(d, 8'h00);
    $display("test reset_values done");
    // Every rate code with random other fields
    for (k = 0; k < 8; k++) begin
      v = 8'($urandom); v[6:4] = 3'(k);
      if (k != 0) v[7] = 1'b1;
      wr(6'h12, v); rd(6'h12, d); check(d, v & 8'hf8);
      check(8'(mode_cfg.send_bit_rate), 8'(k));
      check(8'(mode_cfg.send_rate_legal), 8'(k < 4));
      check(8'(mode_cfg.send_checksum_enable), 8'(v[7]));
      check(8'(mode_cfg.invert_modulation), 8'(v[3]));
      v = 8'($urandom); v[6:4] = 3'(k);
      if (k != 0) v[7] = 1'b1;
      wr(6'h13, v); rd(6'h13, d); check(d, v & 8'hfc);
      check(8'(mode_cfg.receive_bit_rate), 8'(k));
      check(8'(mode_cfg.receive_rate_legal), 8'(k < 4));
      check(8'(mode_cfg.receive_checksum_enable), 8'(v[7]));
      check(8'(mode_cfg.ignore_short_stream), 8'(v[3]));
      check(8'(mode_cfg.multi_frame_receive), 8'(v[2]));
      v = 8'($urandom);
      wr(6'h11, v); rd(6'h11, d); check(d, exp_general(v));
      check(8'({mode_cfg.high_bit_first, mode_cfg.send_wait_for_field,
        mode_cfg.card_input_polarity, mode_cfg.checksum_preset_select}),
        8'({v[7], v[5], v[3], v[1:0]}));
      wr(6'h0f, v); wr(6'h10, ~v);
      rd(6'h0f, d); check(d, 8'h00);
      rd(6'h10, d); check(d, 8'h00);
    end
    $display("test mode_fields done");
    // Single-frame collisions at corner and random positions
    wr(6'h13, 8'h00);
    wr(6'h0e, 8'h80);
    keep_bit = 1'b1;
    pos_tab[5] = 2 + $urandom % 30;
    for (k = 0; k < 6; k++) begin
      c = pos_tab[k];
      done_cnt = 0;
      frame(40, c, 1'b0, 1'b1);
      rd(6'h0e, d);
      check(8'(d[7]), 8'h01);
      if (c != 0 && c <= 32)
        check(8'(d[5:0]), 8'(c % 32));
      else
        check(8'(d[5]), 8'h01);
      check(8'(done_cnt), 8'h01);
      check(8'(rx_active), 8'h00);
    end
    $display("test clash_position done");
    // Keep bit clear drops bits after the clash, receiver at 106 kBd
    wr(6'h0e, 8'h00);
    keep_bit = 1'b0;
    frame(20, 5, 1'b0, 1'b1);
    rd(6'h0e, last); check(last, 8'h05);
    // A frame while idle must leave the result untouched
    frame(12, 2, 1'b0, 1'b0);
    rd(6'h0e, d); check(d, last);
    $display("test keep_and_hold done");
    // Short stream ignored with the receiver left active
    wr(6'h13, 8'h08);
    frame(3, 1, 1'b1, 1'b1);
    check(8'(rx_active), 8'h01);
    rd(6'h0e, d); check(d, last);
    pulse_stop();
    check(8'(rx_active), 8'h00);
    $display("test short_stream done");
    // Multi-frame reception appends an error copy each frame
    wr(6'h13, 8'h04);
    done_cnt = 0;
    app_cnt = 0;
    frame(16, 4, 1'b0, 1'b1);
    check(8'(rx_active), 8'h01);
    check(8'(app_cnt), 8'h01);
    frame(16, 0, 1'b0, 1'b0);
    check(8'(app_cnt), 8'h02);
    check(8'(done_cnt), 8'h00);
    rd(6'h0e, d); check(8'(d[5]), 8'h01);
    pulse_stop();
    check(8'(rx_active), 8'h00);
    $display("test multi_frame done");
    report_and_stop();
  end
endmodule

// >>> dv/rfcm_card_model.sv
// Purpose: card side model that drives the receiver event pulses
// Assumes: one frame at a time, started by a one-cycle go pulse
// Notes:   a parity slot follows every eighth data bit
`timescale 1ns/1ps
module rfcm_card_model
  import rfcm_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          go,
  input  wire logic [6:0]    nbits,
  input  wire logic [6:0]    coll_at,
  input  wire logic          short_f,
  output rfcm_rx_event_type  rx_event,
  output logic               busy
);
  int i;
  initial begin
    rx_event = '0;
    busy = 1'b0;
  end
  // Start pulse, data bits with parity gaps, then the end pulse
  always begin
    @(posedge clk);
    if (go === 1'b1) begin
      busy <= 1'b1;
      rx_event.frame_start <= 1'b1;
      @(posedge clk);
      rx_event.frame_start <= 1'b0;
      for (i = 1; i <= nbits; i++) begin
        rx_event.data_bit <= 1'b1;
        rx_event.bit_collision <= (i == coll_at);
        @(posedge clk);
        if (i % 8 == 0) begin
          rx_event.data_bit <= 1'b0;
          rx_event.bit_collision <= 1'b0;
          @(posedge clk);
        end
      end
      rx_event.data_bit <= 1'b0;
      rx_event.bit_collision <= 1'b0;
      rx_event.frame_end <= 1'b1;
      rx_event.short_stream <= short_f;
      @(posedge clk);
      rx_event.frame_end <= 1'b0;
      rx_event.short_stream <= 1'b0;
      busy <= 1'b0;
    end
  end
endmodule

// >>> shared/rfcm_consts.svh
// Purpose: offsets, field positions and reset values of the mode registers
// Assumes: 6-bit register address, 8-bit register data
// Notes:   included by every design file and by the bench; the package does not include it
`ifndef RFCM_CONSTS_SVH
`define RFCM_CONSTS_SVH

// Register addresses
`define RFCM_ADDR_COLLISION    6'h0e
`define RFCM_ADDR_RSVD_A       6'h0f
`define RFCM_ADDR_RSVD_B       6'h10
`define RFCM_ADDR_GENERAL      6'h11
`define RFCM_ADDR_TRANSMIT     6'h12
`define RFCM_ADDR_RECEIVE      6'h13

// Reset values
`define RFCM_RST_COLLISION     8'ha0
`define RFCM_RST_RSVD          8'h00
`define RFCM_RST_GENERAL       8'h3f
`define RFCM_RST_TRANSMIT      8'h00
`define RFCM_RST_RECEIVE       8'h00

// Writable bit masks
`define RFCM_WMASK_COLLISION   8'h80
`define RFCM_WMASK_GENERAL     8'hab
`define RFCM_WMASK_TRANSMIT    8'hf8
`define RFCM_WMASK_RECEIVE     8'hfc

// Field positions
`define RFCM_BIT_KEEP_AFTER    7
`define RFCM_BIT_POS_INVALID   5
`define RFCM_BIT_HIGH_FIRST    7
`define RFCM_BIT_WAIT_FIELD    5
`define RFCM_BIT_CARD_POL      3
`define RFCM_BIT_CRC_EN        7
`define RFCM_BIT_INV_MOD       3
`define RFCM_BIT_IGNORE_SHORT  3
`define RFCM_BIT_MULTI_FRAME   2

// Rate codes: highest legal code, 848 kBd
`define RFCM_RATE_MAX          3'h3
// Largest one-based position that the 5-bit field can hold
`define RFCM_POS_LIMIT         7'h20

`endif

// >>> shared/rfcm_pkg.sv
// Purpose: types shared by the collision and mode register bank
// Assumes: constants come from rfcm_consts.svh
// Notes:   types only
package rfcm_pkg;

  // Receiver events, all one-cycle pulses on the device clock
  typedef struct packed {
    logic frame_start;
    logic data_bit;
    logic bit_collision;
    logic frame_end;
    logic short_stream;
  } rfcm_rx_event_type;

  // Result of one frame's collision search
  typedef struct packed {
    logic       invalid;
    logic [4:0] position;
  } rfcm_clash_report_type;

  // Settings handed to the transmit and receive paths
  typedef struct packed {
    logic       high_bit_first;
    logic       send_wait_for_field;
    logic       card_input_polarity;
    logic [1:0] checksum_preset_select;
    logic       send_checksum_enable;
    logic [2:0] send_bit_rate;
    logic       send_rate_legal;
    logic       invert_modulation;
    logic       receive_checksum_enable;
    logic [2:0] receive_bit_rate;
    logic       receive_rate_legal;
    logic       ignore_short_stream;
    logic       multi_frame_receive;
    logic       keep_bits_after_clash;
  } rfcm_mode_cfg_type;

  typedef enum logic [0:0] {
    RCV_IDLE,
    RCV_ACTIVE
  } rfcm_rcv_state_type;

endpackage
